// ---- core/bridge_params.svh ----
// Offsets, field positions, reset values and timing counts of the bridge.
// Included by bare name; definitions only.
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

`define DATA_W 32
`define CTRL_OFF 8'h00
`define STAT_OFF 8'h04
`define ARB_OFF 8'h08
`define BAR_OFF 8'h40
`define BAR_END 8'h9f
`define CTRL_RST 8'h00
`define C_SPEED66 0
`define C_INDEP_CLK 1
`define C_SYSRST_EN 2
`define C_TGT_ONLY 3
`define C_ARB_LO 4
`define C_ORDER_DIS 6
`define C_MREQ 7
`define S_SPEED66 5
`define S_PEND 8
`define S_PEND_DONE 9
`define S_GRANTED 10
`define S_SYSRST 11
`define T_HWIRED 2
`define T_BAR64 3
`define ARB_CNT_RST 4'h2
`define ARB_CNT_MAX 4'h8
`define BAR_HW_BASE 32'h8000_0000
`define IO_MASK_MIN 32'hffff_ff00
`define IO_MASK_MAX 32'hffff_fffc
`define CMD_IO_RD 4'h2
`define CMD_IO_WR 4'h3
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define XING_LAT 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/bridge_pkg.sv ----
// Types shared by the bridge modules.
// Assumes bridge_params.svh holds the numeric constants.
package bridge_pkg;
  typedef enum logic [1:0] {ARB_EXTERNAL, ARB_USER, ARB_BUNDLED} arb_mode_t;
  typedef enum logic [1:0] {BAR_UNUSED, BAR_MEM_PF, BAR_MEM_NP, BAR_IO} bar_type_t;
  typedef enum {ST_IDLE, ST_DATA, ST_ISSUE, ST_RESP} pci_state_t;
endpackage

// ---- core/bar_decode.sv ----
// Base address decode and inbound address translation for six BARs.
// Assumes a 32-bit bus; purely combinational, lowest index wins.
`timescale 1ns/100ps
`include "bridge_params.svh"

module bar_decode (
  input wire logic [31:0] addr, // Address phase value
  input wire logic is_io, // Command targets I/O space
  input wire logic [31:0] bar_val [6], // Programmed BAR values
  input wire logic [31:0] bar_mask [6], // Ones on the writable upper bits
  input wire logic [31:0] bar_base [6], // On-chip base per BAR
  input wire logic [3:0] bar_type [6], // Type, hardwire and 64-bit flags
  output logic hit, // Some BAR claims the address
  output logic hit_pf, // Claiming BAR is prefetchable
  output logic [31:0] xaddr // Translated on-chip address
);
  logic [5:0] hv;
  logic [5:0] pfv;
  logic [31:0] xa [6];

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_bar
      logic io_b;
      logic [31:0] m;
      logic [31:0] b;
      assign io_b = bar_type[i][1:0] == bridge_pkg::BAR_IO;
      // I/O windows are clamped to 4..256 bytes
      assign m = io_b ? ((bar_mask[i] | `IO_MASK_MIN) & `IO_MASK_MAX) : bar_mask[i];
      // Hardwired BARs decode a fixed value instead of the programmed one
      assign b = bar_type[i][`T_HWIRED] ? (`BAR_HW_BASE | (32'(i) << 24)) : bar_val[i];
      // A 64-bit BAR needs a 64-bit bus, so it never claims here
      assign hv[i] = (bar_type[i][1:0] != bridge_pkg::BAR_UNUSED) && !bar_type[i][`T_BAR64] &&
                     (io_b == is_io) && ((addr & m) == (b & m));
      assign pfv[i] = bar_type[i][1:0] == bridge_pkg::BAR_MEM_PF;
      assign xa[i] = (bar_base[i] & m) | (addr & ~m);
    end
  endgenerate

  always_comb begin
    hit = 1'b0;
    hit_pf = 1'b0;
    xaddr = addr;
    for (int k = 5; k >= 0; k--) begin
      if (hv[k]) begin
        hit = 1'b1;
        hit_pf = pfv[k];
        xaddr = xa[k];
      end
    end
  end
endmodule

// ---- core/pci_bridge.sv ----
// PCI target bridge to an on-chip master port, with AXI4-Lite setup registers.
// Assumes PCI pins and pci_clk are asynchronous to aclk and are sampled here.
//
// Overview of operation
// - 66-MHz setting shows as 1 in bit 5 of the status word.
// - On-chip data width equals the PCI data width, here 32 bits.
// - Independent system reset clears system logic, never the bridge state.
// - Independent clocking: PCI and system clocks separate, extra latency.
// - Shared clocking: one clock for both sides, lower latency.
// - Target-only mode offers no arbitration; request and grant unused.
// - External arbiter (default): request and grant go to pins.
// - User arbiter: request and grant go to logic, request driver off.
// - Bundled arbiter: bridge is agent 0 on its request and grant.
// - Bundled arbiter serves a configurable count, up to eight, bridge included.
// - Up to six 32-bit BARs; 64-bit BAR only on a 64-bit bus.
// - Ordering disabled in target-only mode lets non-prefetch pass prefetch.
// - Claim only on a BAR hit, then issue on the on-chip bus.
// - Prefetchable BAR gives a burst-capable prefetchable master port.
// - 64-bit BAR needs 64-bit bus, one at most, 2 GBytes max.
// - Non-prefetchable memory BAR hits get single-cycle accesses only.
// - I/O: single cycle, delayed, window 4 to 256 bytes.
// - Translation swaps the BAR's upper bits for the on-chip base.
// - A hardwired BAR uses its fixed value, not run-time programming.
// - Unready read: retry, record, fetch, complete on repeat.
`timescale 1ns/100ps
`include "bridge_params.svh"

module pci_bridge (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte enables
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [7:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  input wire logic pci_clk, // PCI clock pin
  input wire logic pci_frame_n, // Frame pin
  input wire logic pci_irdy_n, // Initiator ready pin
  input wire logic [31:0] pci_ad_i, // Address/data pin input
  input wire logic [3:0] pci_cbe_n, // Command/byte-enable pins
  output logic [31:0] pci_ad_o, // Address/data pin output
  output logic pci_ad_oe, // Address/data drive enable
  output logic pci_trdy_n_o, // Target ready output
  output logic pci_trdy_oe, // Target ready drive enable
  output logic pci_stop_n_o, // Stop (retry) output
  output logic pci_stop_oe, // Stop drive enable
  output logic pci_req_n_o, // Bus request pin output
  output logic pci_req_oe, // Bus request drive enable
  input wire logic pci_gnt_n, // Bus grant pin
  output logic user_req_n, // Request to user arbiter
  input wire logic user_gnt_n, // Grant from user arbiter
  input wire logic [7:1] arbiter_request_inputs_n, // Other agents' requests
  output logic [7:0] arbiter_grant_outputs_n, // Bundled arbiter grants
  output logic m_valid, // On-chip request valid
  input wire logic m_ready, // On-chip request taken
  output logic m_write, // On-chip request is a write
  output logic [31:0] m_addr, // On-chip address
  output logic [`DATA_W-1:0] m_wdata, // On-chip write data
  output logic m_prefetch, // Prefetchable port selected
  input wire logic [`DATA_W-1:0] m_rdata, // On-chip read data
  input wire logic m_rvalid, // On-chip read data valid
  input wire logic sys_rst_n, // Independent system reset pin
  output logic onchip_rst_n // Reset to system logic
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SW = 48;
  logic [SW-1:0] sa_reg;
  logic [SW-1:0] sb_reg;
  logic clk_d_reg;
  always_ff @(posedge aclk) begin
    sa_reg <= {pci_clk, pci_frame_n, pci_irdy_n, pci_gnt_n, sys_rst_n, pci_ad_i, pci_cbe_n,
               arbiter_request_inputs_n};
    sb_reg <= sa_reg;
    clk_d_reg <= sb_reg[47];
  end
  logic pci_rise, frame_s, irdy_s, gnt_s, sysrst_s;
  logic [31:0] ad_s;
  logic [3:0] cmd_s;
  logic [7:1] areq_s;
  assign pci_rise = sb_reg[47] & ~clk_d_reg;
  assign frame_s = sb_reg[46];
  assign irdy_s = sb_reg[45];
  assign gnt_s = sb_reg[44];
  assign sysrst_s = sb_reg[43];
  assign ad_s = sb_reg[42:11];
  assign cmd_s = sb_reg[10:7];
  assign areq_s = sb_reg[6:0];

  ////////////////////////////////////////////////////////////////////////////
  // Setup registers
  logic [7:0] ctrl_reg;
  logic [3:0] arb_cnt_reg;
  logic [31:0] bar_val_reg [6];
  logic [31:0] bar_mask_reg [6];
  logic [31:0] bar_base_reg [6];
  logic [3:0] bar_type_reg [6];
  logic [31:0] status;
  logic [7:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic [31:0] wr_next;
  logic do_wr;
  logic tgt_only, order_dis, indep;
  bridge_pkg::arb_mode_t arb_mode;
  assign tgt_only = ctrl_reg[`C_TGT_ONLY];
  assign order_dis = ctrl_reg[`C_ORDER_DIS];
  assign indep = ctrl_reg[`C_INDEP_CLK];
  assign arb_mode = bridge_pkg::arb_mode_t'(ctrl_reg[`C_ARB_LO +: 2]);

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `CTRL_OFF || a == `STAT_OFF || a == `ARB_OFF || (a >= `BAR_OFF && a <= `BAR_END);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [7:0] o;
    logic [2:0] i;
    o = a - `BAR_OFF;
    i = 3'(o >> 4);
    rd_word = 32'h0000_0000;
    if (a == `CTRL_OFF) rd_word = {24'h00_0000, ctrl_reg};
    else if (a == `STAT_OFF) rd_word = status;
    else if (a == `ARB_OFF) rd_word = {20'h0_0000, arbiter_grant_outputs_n, arb_cnt_reg};
    else if (a >= `BAR_OFF && a <= `BAR_END) begin
      case (o[3:2])
        2'h0: rd_word = bar_val_reg[i];
        2'h1: rd_word = bar_mask_reg[i];
        2'h2: rd_word = bar_base_reg[i];
        default: rd_word = {28'h000_0000, bar_type_reg[i]};
      endcase
    end
  endfunction

  always_comb begin
    wr_next = rd_word(wa_reg);
    for (int b = 0; b < 4; b++) begin
      if (ws_reg[b]) wr_next[8*b +: 8] = wd_reg[8*b +: 8];
    end
  end

  // Held only by aresetn, so the system reset leaves setup intact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RST;
      arb_cnt_reg <= `ARB_CNT_RST;
      for (int k = 0; k < 6; k++) begin
        bar_val_reg[k] <= 32'h0000_0000;
        bar_mask_reg[k] <= 32'h0000_0000;
        bar_base_reg[k] <= 32'h0000_0000;
        bar_type_reg[k] <= 4'h0;
      end
    end else if (do_wr) begin
      if (wa_reg == `CTRL_OFF) ctrl_reg <= wr_next[7:0];
      else if (wa_reg == `ARB_OFF) begin
        if (wr_next[3:0] == 4'h0) arb_cnt_reg <= 4'h1;
        else if (wr_next[3:0] > `ARB_CNT_MAX) arb_cnt_reg <= `ARB_CNT_MAX;
        else arb_cnt_reg <= wr_next[3:0];
      end else if (wa_reg >= `BAR_OFF && wa_reg <= `BAR_END) begin
        case (wa_reg[3:2])
          2'h0: bar_val_reg[3'((wa_reg - `BAR_OFF) >> 4)] <= wr_next;
          2'h1: bar_mask_reg[3'((wa_reg - `BAR_OFF) >> 4)] <= wr_next;
          2'h2: bar_base_reg[3'((wa_reg - `BAR_OFF) >> 4)] <= wr_next;
          default: bar_type_reg[3'((wa_reg - `BAR_OFF) >> 4)] <= wr_next[3:0];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign do_wr = !awready && !wready && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        wa_reg <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_reg <= wdata;
        ws_reg <= wstrb;
        wready <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= mapped(wa_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word(araddr);
      rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request/grant routing and bundled arbiter
  logic bridge_req_n, granted_reg;
  logic [7:0] pick;
  logic [7:0] areq_all;
  assign bridge_req_n = !(ctrl_reg[`C_MREQ] && !tgt_only);
  assign areq_all = {areq_s, bridge_req_n};

  always_comb begin
    pick = 8'hff;
    for (int k = 7; k >= 0; k--) begin
      if (k < 32'(arb_cnt_reg) && !areq_all[k]) pick = ~(8'h01 << k);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arbiter_grant_outputs_n <= 8'hff;
    end else if (arb_mode != bridge_pkg::ARB_BUNDLED || tgt_only) begin
      arbiter_grant_outputs_n <= 8'hff;
    end else if ((~arbiter_grant_outputs_n & ~areq_all) == 8'h00) begin
      arbiter_grant_outputs_n <= pick;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_req_n_o <= 1'b1;
      pci_req_oe <= 1'b0;
      user_req_n <= 1'b1;
      granted_reg <= 1'b0;
    end else begin
      pci_req_n_o <= bridge_req_n;
      pci_req_oe <= !tgt_only && arb_mode == bridge_pkg::ARB_EXTERNAL;
      user_req_n <= tgt_only || arb_mode != bridge_pkg::ARB_USER || bridge_req_n;
      if (tgt_only) granted_reg <= 1'b0;
      else begin
        case (arb_mode)
          bridge_pkg::ARB_USER: granted_reg <= !user_gnt_n;
          bridge_pkg::ARB_BUNDLED: granted_reg <= !arbiter_grant_outputs_n[0];
          default: granted_reg <= !gnt_s;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System reset output
  always_ff @(posedge aclk) begin
    if (!aresetn) onchip_rst_n <= 1'b0;
    else onchip_rst_n <= !(ctrl_reg[`C_SYSRST_EN] && !sysrst_s);
  end

  ////////////////////////////////////////////////////////////////////////////
  // PCI target sequencer and pending delayed transaction
  bridge_pkg::pci_state_t state_reg;
  logic hit, hit_pf;
  logic [31:0] xaddr;
  logic is_io, is_rd, is_wr, cur_pf, pf_busy, blocked, pend_match;
  logic [31:0] addr_reg;
  logic pf_reg, io_reg, more_reg;
  logic pend_valid_reg, pend_done_reg, pend_pf_reg, pend_we_reg, pend_iss_reg;
  logic [31:0] pend_addr_reg, pend_wdata_reg, pend_data_reg, wdata_reg;
  logic rd_wait_reg, src_pend_reg, wr_done;
  logic [1:0] xcnt_reg;

  assign is_io = cmd_s == `CMD_IO_RD || cmd_s == `CMD_IO_WR;
  assign is_rd = cmd_s == `CMD_IO_RD || cmd_s == `CMD_MEM_RD;
  assign is_wr = cmd_s == `CMD_IO_WR || cmd_s == `CMD_MEM_WR;

  bar_decode u_dec (
    .addr(ad_s),
    .is_io(is_io),
    .bar_val(bar_val_reg),
    .bar_mask(bar_mask_reg),
    .bar_base(bar_base_reg),
    .bar_type(bar_type_reg),
    .hit(hit),
    .hit_pf(hit_pf),
    .xaddr(xaddr)
  );

  assign cur_pf = state_reg == bridge_pkg::ST_IDLE ? hit_pf : pf_reg;
  assign pf_busy = (pend_valid_reg && pend_pf_reg && !pend_done_reg) || (m_valid && m_prefetch);
  assign blocked = !cur_pf && pf_busy && !(order_dis && tgt_only);
  assign pend_match = pend_done_reg && !pend_we_reg && pend_addr_reg == xaddr;
  assign wr_done = m_valid && m_ready && !src_pend_reg;
  assign status = {20'h0_0000, !onchip_rst_n, granted_reg, pend_done_reg, pend_valid_reg, 2'h0,
                   ctrl_reg[`C_SPEED66], 5'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= bridge_pkg::ST_IDLE;
      {pci_trdy_n_o, pci_stop_n_o} <= 2'b11;
      {pci_trdy_oe, pci_stop_oe, pci_ad_oe} <= 3'b000;
      pci_ad_o <= 32'h0000_0000;
      {pf_reg, io_reg, more_reg} <= 3'b000;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      {pend_valid_reg, pend_done_reg, pend_pf_reg, pend_we_reg} <= 4'h0;
      pend_addr_reg <= 32'h0000_0000;
      pend_wdata_reg <= 32'h0000_0000;
      pend_data_reg <= 32'h0000_0000;
    end else begin
      if (m_rvalid && rd_wait_reg) begin
        pend_data_reg <= m_rdata;
        pend_done_reg <= 1'b1;
      end
      if (m_valid && m_ready && src_pend_reg && m_write) pend_done_reg <= 1'b1;
      case (state_reg)
        bridge_pkg::ST_IDLE: begin
          if (pci_rise && !frame_s && hit && (is_rd || is_wr)) begin
            addr_reg <= xaddr;
            pf_reg <= hit_pf;
            io_reg <= is_io;
            if (is_wr) state_reg <= bridge_pkg::ST_DATA;
            else begin
              state_reg <= bridge_pkg::ST_RESP;
              if (pend_match) begin
                pci_ad_o <= pend_data_reg;
                {pci_ad_oe, pci_trdy_oe, pci_trdy_n_o} <= 3'b110;
                {pend_valid_reg, pend_done_reg} <= 2'b00;
              end else begin
                {pci_stop_oe, pci_stop_n_o} <= 2'b10;
                if (!pend_valid_reg && !blocked) begin
                  {pend_valid_reg, pend_we_reg} <= 2'b10;
                  pend_pf_reg <= hit_pf;
                  pend_addr_reg <= xaddr;
                end
              end
            end
          end
        end
        bridge_pkg::ST_DATA: begin
          if (pci_rise && !irdy_s) begin
            if (io_reg) begin
              state_reg <= bridge_pkg::ST_RESP;
              if (pend_done_reg && pend_we_reg && pend_addr_reg == addr_reg) begin
                {pci_trdy_oe, pci_trdy_n_o} <= 2'b10;
                {pend_valid_reg, pend_done_reg} <= 2'b00;
              end else begin
                {pci_stop_oe, pci_stop_n_o} <= 2'b10;
                if (!pend_valid_reg) begin
                  {pend_valid_reg, pend_we_reg, pend_pf_reg} <= 3'b110;
                  pend_addr_reg <= addr_reg;
                  pend_wdata_reg <= ad_s;
                end
              end
            end else if (blocked) begin
              state_reg <= bridge_pkg::ST_RESP;
              {pci_stop_oe, pci_stop_n_o} <= 2'b10;
              more_reg <= 1'b0;
            end else begin
              wdata_reg <= ad_s;
              more_reg <= pf_reg && !frame_s;
              state_reg <= bridge_pkg::ST_ISSUE;
            end
          end
        end
        bridge_pkg::ST_ISSUE: begin
          if (wr_done) begin
            {pci_trdy_oe, pci_trdy_n_o} <= 2'b10;
            state_reg <= bridge_pkg::ST_RESP;
          end
        end
        bridge_pkg::ST_RESP: begin
          if (pci_rise) begin
            {pci_trdy_n_o, pci_stop_n_o} <= 2'b11;
            {pci_trdy_oe, pci_stop_oe, pci_ad_oe} <= 3'b000;
            if (more_reg) begin
              addr_reg <= addr_reg + 32'h0000_0004;
              state_reg <= bridge_pkg::ST_DATA;
            end else state_reg <= bridge_pkg::ST_IDLE;
            more_reg <= 1'b0;
          end
        end
        default: state_reg <= bridge_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // On-chip master: one request in flight, posted writes before fetches
  logic want_wr, want_rd, launch;
  assign want_wr = state_reg == bridge_pkg::ST_ISSUE;
  assign want_rd = pend_valid_reg && !pend_done_reg && !pend_iss_reg;
  // Independent clocking pays a fixed crossing delay per request
  assign launch = (want_wr || want_rd) && !m_valid && !rd_wait_reg &&
                  (!indep || xcnt_reg == `XING_LAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {m_valid, m_write, m_prefetch, rd_wait_reg, src_pend_reg, pend_iss_reg} <= 6'h00;
      m_addr <= 32'h0000_0000;
      m_wdata <= 32'h0000_0000;
      xcnt_reg <= 2'h0;
    end else begin
      if (!pend_valid_reg) pend_iss_reg <= 1'b0;
      if ((want_wr || want_rd) && !m_valid && !rd_wait_reg && !launch) xcnt_reg <= xcnt_reg + 2'h1;
      if (launch) begin
        xcnt_reg <= 2'h0;
        m_valid <= 1'b1;
        if (want_wr) begin
          {m_write, src_pend_reg} <= 2'b10;
          m_addr <= addr_reg;
          m_wdata <= wdata_reg;
          m_prefetch <= pf_reg;
        end else begin
          {m_write, src_pend_reg, pend_iss_reg} <= {pend_we_reg, 2'b11};
          m_addr <= pend_addr_reg;
          m_wdata <= pend_wdata_reg;
          m_prefetch <= pend_pf_reg;
        end
      end else if (m_valid && m_ready) begin
        m_valid <= 1'b0;
        rd_wait_reg <= !m_write;
      end else if (rd_wait_reg && m_rvalid) begin
        rd_wait_reg <= 1'b0;
      end
    end
  end
endmodule

// ---- sim/onchip_model.sv ----
// On-chip peripheral model behind the bridge master port.
// Assumes one request at a time on aclk, data is the inverted address.
`timescale 1ns/100ps
module onchip_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic m_valid, // Request
  input wire logic m_write, // Write flag
  input wire logic [31:0] m_addr, // Address
  input wire logic [31:0] m_wdata, // Write data
  output logic m_ready, // Taken
  output logic m_rvalid, // Read data valid
  output logic [31:0] m_rdata, // Read data
  output logic [31:0] wr_addr, // Last write address
  output logic [31:0] wr_data // Last write data
);
  // Ready one cycle late; idle data toggles so stale values never match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_ready <= 1'b0;
      m_rvalid <= 1'b0;
      m_rdata <= 32'h0000_0000;
    end else begin
      m_ready <= m_valid && !m_ready;
      m_rvalid <= m_valid && m_ready && !m_write;
      m_rdata <= (m_valid && m_ready) ? ~m_addr : ~m_rdata;
      if (m_valid && m_ready && m_write) begin
        wr_addr <= m_addr;
        wr_data <= m_wdata;
      end
    end
  end
endmodule

// ---- sim/pci_bridge_checker.sv ----
// Protocol assertions on the bridge top ports.
// Assumes the aclk domain and bind by name.
`timescale 1ns/100ps
module pci_bridge_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic m_valid, // Request
  input wire logic m_ready, // Taken
  input wire logic [31:0] m_addr, // Address
  input wire logic pci_trdy_oe, // Done drive
  input wire logic pci_trdy_n_o, // Done level
  input wire logic pci_stop_oe, // Retry drive
  input wire logic pci_stop_n_o, // Retry level
  input wire logic pci_ad_oe, // Data drive
  input wire logic pci_req_oe, // Pin request drive
  input wire logic user_req_n, // User request
  input wire logic [7:0] arbiter_grant_outputs_n // Grants
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_retry; pci_stop_oe && !pci_stop_n_o; endsequence
  sequence s_done; pci_trdy_oe && !pci_trdy_n_o; endsequence
  a_retry_release: assert property (s_retry |-> ##[1:20] !pci_stop_oe) else $error("retry stuck");
  a_done_release: assert property (s_done |-> ##[1:20] !pci_trdy_oe) else $error("done stuck");
  a_done_no_retry: assert property (s_done |-> !(pci_stop_oe && !pci_stop_n_o)) else $error("both");
  a_data_with_done: assert property (pci_ad_oe |-> s_done) else $error("data alone");
  a_user_no_pin: assert property (!user_req_n |-> !pci_req_oe) else $error("pin on");
  a_grant_single: assert property ($onehot0(~arbiter_grant_outputs_n)) else $error("grants");
  a_agent0_inside: assert property (!arbiter_grant_outputs_n[0] |-> user_req_n && !pci_req_oe) else $error("a0");
  a_pin_external: assert property (pci_req_oe |-> &arbiter_grant_outputs_n && user_req_n) else $error("ext");
  a_onchip_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_addr)) else $error("drop");
endmodule
bind pci_bridge pci_bridge_checker u_chk (.*);

// ---- sim/tb_pci_to_onchip_bus_bridge_config.sv ----
// Self-checking bench for the bridge setup, decode and arbitration.
// Assumes onchip_model and the bound checker.
`timescale 1ns/100ps
module tb_pci_to_onchip_bus_bridge_config;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, arbiter_grant_outputs_n;
  logic [31:0] wdata, rdata, pci_ad_i, pci_ad_o, m_addr, m_wdata, m_rdata, wr_addr, wr_data, rv, q;
  logic [3:0] wstrb, pci_cbe_n;
  logic [1:0] bresp, rresp, rs, r;
  logic pci_clk, pci_frame_n, pci_irdy_n, pci_ad_oe, pci_trdy_n_o, pci_trdy_oe, pci_stop_n_o, pci_stop_oe;
  logic pci_req_n_o, pci_req_oe, pci_gnt_n, user_req_n, user_gnt_n, m_valid, m_ready, m_write;
  logic m_prefetch, m_rvalid, sys_rst_n, onchip_rst_n;
  logic [7:1] arbiter_request_inputs_n;
  int failures = 0, cmp_count = 0;
  pci_bridge uut (.*);
  onchip_model mdl (.*);
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    pci_clk = 0;
    forever #40 pci_clk = ~pci_clk;
  end
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rv = rdata; rs = rresp; rready <= 0;
    @(posedge aclk);
  endtask
  // One PCI transfer; r collects {retry, done}, q the returned data
  task pci(input [31:0] a, input [3:0] c, input [31:0] dt);
    @(negedge pci_clk); @(posedge aclk);
    pci_frame_n <= 0; pci_ad_i <= a; pci_cbe_n <= c;
    @(negedge pci_clk); @(posedge aclk);
    pci_frame_n <= 1; pci_irdy_n <= 0; pci_ad_i <= dt; pci_cbe_n <= 0; r = 0; q = 0;
    repeat (60) begin
      @(posedge aclk);
      r |= {pci_stop_oe & !pci_stop_n_o, pci_trdy_oe & !pci_trdy_n_o};
      if (pci_ad_oe) q = pci_ad_o;
    end
    pci_irdy_n <= 1; pci_ad_i <= ~dt;
  endtask
  ////////////////////////////////////////
  task t_regs;
    wr(8'h00, 1); rd(8'h04); chk("speed", rv[5], 1);
    rd(8'h08); chk("agents", rv[3:0], 2);
    wr(8'h08, 9); rd(8'h08); chk("agents max", rv[3:0], 8);
    rd(8'h10); chk("unmapped", rs, 2);
    wr(8'h10, 1); chk("wr unmapped", bresp, 2);
    $display("t_regs done");
  endtask
  task t_bar;
    wr(8'h40, 32'h1000_0000); wr(8'h44, 32'hfff0_0000); wr(8'h48, 32'h0a00_0000); wr(8'h4c, 2);
    wr(8'h54, 32'hfff0_0000); wr(8'h58, 32'h0b00_0000); wr(8'h5c, 5);
    pci(32'h1000_1234, 4'h7, 32'hcafe_0001); chk("claim", r, 1);
    chk("xaddr", wr_addr, 32'h0a00_1234);
    chk("wdata", wr_data, 32'hcafe_0001);
    chk("np port", m_prefetch, 0);
    pci(32'h8100_0040, 4'h7, 5); chk("hw addr", wr_addr, 32'h0b00_0040);
    chk("pf port", m_prefetch, 1);
    pci(32'h2000_0000, 4'h7, 7); chk("miss", r, 0);
    $display("t_bar done");
  endtask
  task t_read;
    wr(8'h00, 2);
    pci(32'h1000_0010, 4'h6, 0); chk("retry", r, 2);
    repeat (20) @(posedge aclk);
    pci(32'h1000_0010, 4'h6, 0); chk("done", r, 1);
    chk("rdata", q, ~32'h0a00_0010);
    $display("t_read done");
  endtask
  task t_arb;
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m == 3 ? 32'h88 : 32'h80 | (m << 4));
      repeat (8) @(posedge aclk);
      chk("pin req", pci_req_oe, m == 0);
      chk("user req", user_req_n, m != 1);
      chk("grant0", arbiter_grant_outputs_n[0], m != 2);
      chk("req level", pci_req_n_o, m == 3);
    end
    $display("t_arb done");
  endtask
  task t_sysrst;
    wr(8'h00, 4); sys_rst_n <= 0;
    repeat (6) @(posedge aclk);
    chk("sys rst", onchip_rst_n, 0);
    rd(8'h00); chk("ctrl kept", rv, 4);
    sys_rst_n <= 1;
    repeat (6) @(posedge aclk);
    chk("sys run", onchip_rst_n, 1);
    $display("t_sysrst done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {pci_frame_n, pci_irdy_n, pci_gnt_n, sys_rst_n} = '1;
    user_gnt_n = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; pci_ad_i = 0; pci_cbe_n = 0;
    arbiter_request_inputs_n = '1;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    t_regs; t_bar; t_read; t_arb; t_sysrst;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test;
  end
endmodule
